// file: src/cq_sideband_defines.vh
// constants shared by the completer request sideband block
`ifndef CQ_SIDEBAND_DEFINES_VH
`define CQ_SIDEBAND_DEFINES_VH

// register byte offsets
`define REG_CTRL_OFS        12'h000
`define REG_IRQ_STATUS_OFS  12'h004
`define REG_IRQ_MASK_OFS    12'h008
`define REG_PKT_COUNT_OFS   12'h00C
`define REG_DISC_COUNT_OFS  12'h010

// control register fields and reset value
`define CTRL_WIDTH_LSB      0
`define CTRL_WIDTH_MSB      1
`define CTRL_ENDPOINT_BIT   2
`define CTRL_RESET          32'h0000_0006

// interrupt status / mask bits
`define IRQ_DISCONTINUE_BIT 0
`define IRQ_PACKET_BIT      1
`define IRQ_WIDTH           2
`define IRQ_MASK_RESET      2'h0

// data width codes
`define WIDTH_64            2'h0
`define WIDTH_128           2'h1
`define WIDTH_256           2'h2

// beat geometry
`define DATA_BITS           256
`define LANES               8
`define DESC_DWORDS         12'h004

// sideband layout
`define SB_BITS             42
`define SB_FIRST_LSB        0
`define SB_FIRST_MSB        3
`define SB_LAST_LSB         4
`define SB_LAST_MSB         7
`define SB_BYTE_LSB         8
`define SB_BYTE_MSB         39
`define SB_SOP_BIT          40
`define SB_DISC_BIT         41

// request kinds from the header decoder
`define KIND_MEM_RD         3'h0
`define KIND_MEM_WR         3'h1
`define KIND_IO_RD          3'h2
`define KIND_IO_WR          3'h3
`define KIND_ATOMIC         3'h4
`define KIND_MSG            3'h5
`define KIND_MSG_DATA       3'h6
`define KIND_OTHER          3'h7

`endif

// file: src/dword_lane_flags.v
// payload byte flags for one dword lane of a request beat
`timescale 1ns/10ps
`include "cq_sideband_defines.vh"

module dword_lane_flags
#(
    parameter [11:0] LANE = 12'h000
)
(
    input  wire [11:0] beat_base,
    input  wire        lane_on,
    input  wire        has_payload,
    input  wire [10:0] len_dw,
    input  wire [3:0]  first_mask,
    input  wire [3:0]  last_mask,
    output reg  [3:0]  flags
);

    wire [11:0] idx;
    wire [11:0] pay_idx;
    wire        in_pay;

    assign idx     = beat_base + LANE;
    assign pay_idx = idx - `DESC_DWORDS;
    // descriptor dwords never raise flags
    assign in_pay  = lane_on & has_payload & (idx >= `DESC_DWORDS) &
                     (pay_idx < {1'b0, len_dw});

    always @*
    begin
        if (!in_pay)
            flags = 4'h0;
        else if (pay_idx == 12'h000)
            flags = first_mask;
        else if (pay_idx == ({1'b0, len_dw} - 12'h001))
            flags = last_mask;
        else
            flags = 4'hF;
    end

endmodule

// file: src/cq_request_sideband.v
// completer request stream stage that builds the per-beat sideband word
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "cq_sideband_defines.vh"

module cq_request_sideband
(
    input  wire                  clk,
    input  wire                  rst_b,
    // apb slave
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [11:0]           paddr,
    input  wire [31:0]           pwdata,
    output reg  [31:0]           prdata,
    output reg                   pready,
    output reg                   pslverr,
    output reg                   irq,
    // internal request source
    input  wire                  src_valid,
    output wire                  src_ready,
    input  wire [`DATA_BITS-1:0] src_data,
    input  wire                  src_sop,
    input  wire                  src_last,
    input  wire [2:0]            src_kind,
    input  wire [10:0]           src_len_dw,
    input  wire [3:0]            src_first_dword_byte_mask,
    input  wire [3:0]            src_last_dword_byte_mask,
    input  wire                  src_payload_err,
    // completer request stream to user logic
    output reg  [`DATA_BITS-1:0] request_data_bus,
    output reg  [`SB_BITS-1:0]   request_sideband_bus,
    output reg                   request_beat_valid,
    input  wire                  request_beat_ready,
    output reg                   request_final_beat,
    // uncorrectable error report toward the error reporting logic
    output reg                   aer_payload_err_report
);

    reg  [31:0]            ctrl_r;
    reg  [`IRQ_WIDTH-1:0]  irq_status_r;
    reg  [`IRQ_WIDTH-1:0]  irq_status_nxt;
    reg  [`IRQ_WIDTH-1:0]  irq_mask_r;
    reg  [31:0]            pkt_count_r;
    reg  [31:0]            disc_count_r;
    reg  [31:0]            rd_mux;
    reg                    addr_hit;

    reg  [2:0]             kind_r;
    reg  [10:0]            len_r;
    reg  [3:0]             first_r;
    reg  [3:0]             last_r;
    reg  [1:0]             width_r;
    reg  [11:0]            base_r;
    reg                    err_acc_r;

    wire                   take;
    wire                   out_fire;
    wire                   apb_setup;
    wire                   apb_wr;
    wire [2:0]             cur_kind;
    wire [10:0]            cur_len;
    wire [3:0]             cur_first;
    wire [3:0]             cur_last;
    wire [1:0]             cur_width;
    wire [11:0]            cur_base;
    wire [11:0]            beat_dwords;
    wire                   cur_err;
    wire                   has_payload;
    wire                   mem_rw;
    wire                   full_masks;
    reg  [3:0]             first_mask;
    reg  [3:0]             last_mask;
    reg  [`LANES-1:0]      lane_on;
    wire [31:0]            byte_flags;
    wire                   disc_now;
    wire                   disc_accept;
    wire                   sop_accept;

    // one-entry output stage; refill only when empty or draining
    assign out_fire  = request_beat_valid & request_beat_ready;
    assign src_ready = ~request_beat_valid | request_beat_ready;
    assign take      = src_valid & src_ready;

    // header fields come live on the start beat, held afterwards
    assign cur_kind  = src_sop ? src_kind : kind_r;
    assign cur_len   = src_sop ? src_len_dw : len_r;
    assign cur_first = src_sop ? src_first_dword_byte_mask : first_r;
    assign cur_last  = src_sop ? src_last_dword_byte_mask : last_r;
    // width sampled per packet so a reconfigure cannot tear a packet
    assign cur_width = src_sop ? ctrl_r[`CTRL_WIDTH_MSB:`CTRL_WIDTH_LSB]
                               : width_r;
    assign cur_base  = src_sop ? 12'h000 : base_r;
    assign cur_err   = (~src_sop & err_acc_r) | src_payload_err;

    assign beat_dwords = (cur_width == `WIDTH_64)  ? 12'h002 :
                         (cur_width == `WIDTH_128) ? 12'h004 : 12'h008;

    assign mem_rw      = (cur_kind == `KIND_MEM_RD) |
                         (cur_kind == `KIND_MEM_WR);
    assign full_masks  = (cur_kind == `KIND_ATOMIC) |
                         (cur_kind == `KIND_MSG_DATA);
    assign has_payload = (cur_kind == `KIND_MEM_WR) |
                         (cur_kind == `KIND_IO_WR) | full_masks;

    always @*
    begin
        if (full_masks)
        begin
            first_mask = 4'hF;
            last_mask  = 4'hF;
        end
        else if (mem_rw && cur_len <= 11'h001)
        begin
            first_mask = cur_first;
            last_mask  = 4'h0;
        end
        else
        begin
            first_mask = cur_first;
            last_mask  = cur_last;
        end
    end

    always @*
    begin
        case (cur_width)
            `WIDTH_64:  lane_on = 8'h03;
            `WIDTH_128: lane_on = 8'h0F;
            `WIDTH_256: lane_on = 8'hFF;
            default:    lane_on = 8'hFF;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < `LANES; g = g + 1)
        begin : lane
            dword_lane_flags
            #(
                .LANE        (g[11:0])
            )
            u_flags
            (
                .beat_base   (cur_base),
                .lane_on     (lane_on[g]),
                .has_payload (has_payload),
                .len_dw      (cur_len),
                .first_mask  (first_mask),
                .last_mask   (last_mask),
                .flags       (byte_flags[4*g+3:4*g])
            );
        end
    endgenerate

    assign disc_now    = src_last & cur_err & has_payload;
    assign disc_accept = out_fire &
                         request_sideband_bus[`SB_DISC_BIT];
    assign sop_accept  = out_fire &
                         request_sideband_bus[`SB_SOP_BIT];

    // packet tracking state
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            kind_r    <= `KIND_OTHER;
            len_r     <= 11'h000;
            first_r   <= 4'h0;
            last_r    <= 4'h0;
            width_r   <= `WIDTH_256;
            base_r    <= 12'h000;
            err_acc_r <= 1'b0;
        end
        else if (take)
        begin
            kind_r    <= cur_kind;
            len_r     <= cur_len;
            first_r   <= cur_first;
            last_r    <= cur_last;
            width_r   <= cur_width;
            base_r    <= cur_base + beat_dwords;
            // error sticks until the final beat carries it out
            err_acc_r <= cur_err & ~src_last;
        end
    end

    // output beat register; held untouched while ready is low
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            request_data_bus     <= {`DATA_BITS{1'b0}};
            request_sideband_bus <= {`SB_BITS{1'b0}};
            request_beat_valid   <= 1'b0;
            request_final_beat   <= 1'b0;
        end
        else if (take)
        begin
            request_data_bus   <= src_data;
            request_beat_valid <= 1'b1;
            request_final_beat <= src_last;
            // masks only driven on the start beat, zero elsewhere
            request_sideband_bus[`SB_FIRST_MSB:`SB_FIRST_LSB] <=
                src_sop ? first_mask : 4'h0;
            request_sideband_bus[`SB_LAST_MSB:`SB_LAST_LSB] <=
                src_sop ? last_mask : 4'h0;
            request_sideband_bus[`SB_BYTE_MSB:`SB_BYTE_LSB] <=
                byte_flags;
            request_sideband_bus[`SB_SOP_BIT] <= src_sop;
            request_sideband_bus[`SB_DISC_BIT] <= disc_now;
        end
        else if (out_fire)
        begin
            request_beat_valid <= 1'b0;
        end
    end

    // error report fires once per discontinued request while the endpoint bit is set
    always @(posedge clk)
    begin
        if (!rst_b)
            aer_payload_err_report <= 1'b0;
        else
            aer_payload_err_report <= disc_accept &
                ctrl_r[`CTRL_ENDPOINT_BIT];
    end

    // apb: setup loads read data, access answers one cycle later
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pwrite & pready;

    always @*
    begin
        addr_hit = 1'b1;
        case (paddr)
            `REG_CTRL_OFS:       rd_mux = ctrl_r;
            `REG_IRQ_STATUS_OFS: rd_mux = {30'h0, irq_status_r};
            `REG_IRQ_MASK_OFS:   rd_mux = {30'h0, irq_mask_r};
            `REG_PKT_COUNT_OFS:  rd_mux = pkt_count_r;
            `REG_DISC_COUNT_OFS: rd_mux = disc_count_r;
            default:
            begin
                rd_mux   = 32'h0000_0000;
                addr_hit = 1'b0;
            end
        endcase
    end

    // new events win over a same-cycle write-one clear
    always @*
    begin
        irq_status_nxt = irq_status_r;
        if (apb_wr && paddr == `REG_IRQ_STATUS_OFS)
            irq_status_nxt = irq_status_nxt & ~pwdata[`IRQ_WIDTH-1:0];
        if (disc_accept)
            irq_status_nxt[`IRQ_DISCONTINUE_BIT] = 1'b1;
        if (sop_accept)
            irq_status_nxt[`IRQ_PACKET_BIT] = 1'b1;
    end

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready <= apb_setup;
            if (apb_setup)
            begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= ~addr_hit;
            end
            else
            begin
                pslverr <= 1'b0;
            end
        end
    end

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            ctrl_r       <= `CTRL_RESET;
            irq_status_r <= {`IRQ_WIDTH{1'b0}};
            irq_mask_r   <= `IRQ_MASK_RESET;
            irq          <= 1'b0;
        end
        else
        begin
            if (apb_wr && paddr == `REG_CTRL_OFS)
                ctrl_r <= {29'h0, pwdata[2:0]};
            if (apb_wr && paddr == `REG_IRQ_MASK_OFS)
                irq_mask_r <= pwdata[`IRQ_WIDTH-1:0];
            irq_status_r <= irq_status_nxt;
            irq          <= |(irq_status_nxt & irq_mask_r);
        end
    end

    // counters wrap; software takes differences
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            pkt_count_r  <= 32'h0000_0000;
            disc_count_r <= 32'h0000_0000;
        end
        else
        begin
            if (sop_accept)
                pkt_count_r <= pkt_count_r + 32'h0000_0001;
            if (disc_accept)
                disc_count_r <= disc_count_r + 32'h0000_0001;
        end
    end

endmodule

// file: test/cq_sideband_checker.sv
// assertions on the ports of the completer request sideband stage
`timescale 1ns/10ps
`include "cq_sideband_defines.vh"
module cq_sideband_checker
(
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic                  src_valid,
    input wire logic                  src_ready,
    input wire logic                  src_sop,
    input wire logic [2:0]            src_kind,
    input wire logic [10:0]           src_len_dw,
    input wire logic [3:0]            src_first_dword_byte_mask,
    input wire logic [`DATA_BITS-1:0] request_data_bus,
    input wire logic [`SB_BITS-1:0]   request_sideband_bus,
    input wire logic                  request_beat_valid,
    input wire logic                  request_beat_ready,
    input wire logic                  request_final_beat,
    input wire logic                  aer_payload_err_report
);
    wire         take = src_valid && src_ready;
    wire         hold = request_beat_valid && !request_beat_ready;
    wire         mem  = src_kind == `KIND_MEM_WR || src_kind == `KIND_MEM_RD;
    wire [41:0]  sb   = request_sideband_bus;
    wire         disc_acc = request_beat_valid && request_beat_ready && sb[41];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    hold_beat_a: assert property (hold |=> request_beat_valid &&
        $stable(sb) && $stable(request_data_bus)
        && $stable(request_final_beat)) else $error("beat changed");
    take_answer_a: assert property (take |=> request_beat_valid)
        else $error("taken beat not offered");
    sop_mark_a: assert property (take && src_sop |=> sb[40])
        else $error("start marker missing");
    first_mask_a: assert property (take && src_sop &&
        src_kind == `KIND_MEM_WR |=> sb[3:0] ==
        $past(src_first_dword_byte_mask)) else $error("first mask");
    short_mem_a: assert property (take && src_sop && mem &&
        src_len_dw <= 11'h001 |=> sb[7:4] == 4'h0) else $error("last mask");
    atomic_masks_a: assert property (take && src_sop &&
        src_kind == `KIND_ATOMIC |=> sb[7:0] == 8'hFF) else $error("atomic");
    masks_sop_a: assert property (request_beat_valid && !sb[40]
        |-> sb[7:0] == 8'h00) else $error("masks off start beat");
    disc_final_a: assert property (request_beat_valid && sb[41]
        |-> request_final_beat) else $error("discontinue off final");
    err_report_a: assert property ($rose(aer_payload_err_report)
        |-> $past(disc_acc)) else $error("report without cause");

    cover property (disc_acc);
    cover property (hold);
    cover property (request_beat_valid && request_beat_ready && sb[40] &&
        request_final_beat);
endmodule

bind cq_request_sideband cq_sideband_checker i_cq_sideband_checker
(
    .clk, .rst_b, .src_valid, .src_ready, .src_sop, .src_kind, .src_len_dw,
    .src_first_dword_byte_mask, .request_data_bus, .request_sideband_bus,
    .request_beat_valid, .request_beat_ready, .request_final_beat,
    .aer_payload_err_report
);

// file: test/cq_user_sink.sv
// user logic model that takes completer request beats
`timescale 1ns/10ps
module cq_user_sink
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       valid,
    input  wire logic       final_beat,
    input  wire logic       disc,
    output logic            ready,
    output logic [7:0]      kept,
    output logic [7:0]      dropped
);
    logic [1:0] pace;
    // stall one cycle in four so held beats get exercised
    assign ready = pace != 2'h3;
    always @(posedge clk)
        if (!rst_b)
        begin
            pace <= 2'h0;
            kept <= 8'h00;
            dropped <= 8'h00;
        end
        else
        begin
            pace <= pace + 2'h1;
            if (valid && ready && final_beat)
                if (disc)
                    dropped <= dropped + 8'h01;
                else
                    kept <= kept + 8'h01;
        end
endmodule

// file: test/cq_request_sideband_tb.sv
// self-checking bench for the completer request sideband stage
`timescale 1ns/10ps
`include "cq_sideband_defines.vh"
module cq_request_sideband_tb;
    logic clk = 1'b0, rst_b = 1'b0, aer_seen = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, se;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, src_ready, src_valid = 1'b0;
    logic src_sop = 1'b0, src_last = 1'b0, src_payload_err = 1'b0;
    logic [`DATA_BITS-1:0] src_data = '0, request_data_bus;
    logic [2:0] src_kind = 3'h0;
    logic [10:0] src_len_dw = 11'h000;
    logic [3:0] src_first_dword_byte_mask = 4'h0;
    logic [3:0] src_last_dword_byte_mask = 4'h0;
    logic [41:0] request_sideband_bus, got[$];
    logic request_beat_valid, request_beat_ready, request_final_beat;
    logic aer_payload_err_report;
    logic [7:0] kept, dropped;
    int err_count = 0, total_checks = 0, cyc = 0, beats = 0;
    logic [2:0] tk[6] = '{3'h1, 3'h1, 3'h0, 3'h4, 3'h6, 3'h1};
    logic [10:0] tn[6] = '{11'h3, 11'h1, 11'h1, 11'h2, 11'h1, 11'h2};
    logic [7:0] tm[6] = '{8'h3E, 8'h50, 8'hFF, 8'h21, 8'h00, 8'h5A};
    logic [41:0] tx[6] = '{{2'h1, 32'h03FE0000, 8'h3E}, {2'h1, 32'h0, 8'h0},
        {2'h1, 32'h0, 8'h0F}, {2'h1, 32'h00FF0000, 8'hFF},
        {2'h1, 32'h000F0000, 8'hFF}, {2'h1, 32'h005A0000, 8'h5A}};

    always #4 clk = ~clk;

    cq_request_sideband i_cq_request_sideband (.clk, .rst_b, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
        .src_valid, .src_ready, .src_data, .src_sop, .src_last, .src_kind,
        .src_len_dw, .src_first_dword_byte_mask, .src_last_dword_byte_mask,
        .src_payload_err, .request_data_bus, .request_sideband_bus,
        .request_beat_valid, .request_beat_ready, .request_final_beat,
        .aer_payload_err_report);
    cq_user_sink i_cq_user_sink (.clk, .rst_b, .valid(request_beat_valid),
        .final_beat(request_final_beat), .disc(request_sideband_bus[41]),
        .ready(request_beat_ready), .kept, .dropped);

    task final_report;
        if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string n, input logic [41:0] e, input logic [41:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // mask inputs are only sampled on the start beat
    task beat(input logic s, l, input logic [2:0] k, input logic [10:0] n,
              input logic [7:0] m, input logic e);
        src_valid <= 1'b1;
        src_sop <= s;
        src_last <= l;
        src_kind <= k;
        src_len_dw <= n;
        {src_last_dword_byte_mask, src_first_dword_byte_mask} <= m;
        src_payload_err <= e;
        src_data <= ~src_data;
        do @(posedge clk); while (src_ready !== 1'b1);
    endtask
    task pop(input logic [41:0] e);
        for (int i = 0; i < 60 && got.size() == 0; i++)
            @(posedge clk);
        chk("sideband", e, got.size() ? got.pop_front() : 'x);
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (request_beat_valid && request_beat_ready)
        begin
            got.push_back(request_sideband_bus);
            // source data toggles every beat, first beat all ones
            chk("data", {42{~beats[0]}}, request_data_bus[41:0]);
            beats <= beats + 1;
        end
        if (aer_payload_err_report === 1'b1)
            aer_seen <= 1'b1;
        if (cyc == 6000)
        begin
            err_count++;
            final_report;
        end
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, `REG_CTRL_OFS, 32'h0);
        chk("ctrl", `CTRL_RESET, rd);
        apb(1'b0, `REG_IRQ_MASK_OFS, 32'h0);
        chk("mask", 42'h0, rd);
        apb(1'b0, 12'h014, 32'h0);
        chk("slverr", 42'h1, se);
        for (int i = 0; i < 6; i++)
            beat(1'b1, 1'b1, tk[i], tn[i], tm[i], i == 2);
        src_valid <= 1'b0;
        for (int i = 0; i < 6; i++)
            pop(tx[i]);
        beat(1'b1, 1'b0, `KIND_MEM_WR, 11'hA, 8'h1F, 1'b1);
        beat(1'b0, 1'b1, `KIND_MEM_WR, 11'hA, 8'h1F, 1'b0);
        src_valid <= 1'b0;
        pop({2'h1, 32'hFFFF0000, 8'h1F});
        pop({2'h2, 32'h001FFFFF, 8'h00});
        apb(1'b1, `REG_IRQ_MASK_OFS, 32'h1);
        apb(1'b0, `REG_IRQ_STATUS_OFS, 32'h0);
        chk("status", 42'h3, rd);
        chk("irq", 42'h1, irq);
        apb(1'b1, `REG_IRQ_STATUS_OFS, 32'h1);
        apb(1'b0, `REG_IRQ_STATUS_OFS, 32'h0);
        chk("status", 42'h2, rd);
        chk("irq", 42'h0, irq);
        apb(1'b0, `REG_DISC_COUNT_OFS, 32'h0);
        chk("disc count", 42'h1, rd);
        apb(1'b0, `REG_PKT_COUNT_OFS, 32'h0);
        chk("pkt count", 42'h7, rd);
        chk("aer", 42'h1, aer_seen);
        chk("dropped", 42'h1, dropped);
        apb(1'b1, `REG_CTRL_OFS, 32'h5);
        beat(1'b1, 1'b0, `KIND_MEM_WR, 11'h3, 8'h3E, 1'b0);
        beat(1'b0, 1'b1, `KIND_MEM_WR, 11'h3, 8'h3E, 1'b0);
        src_valid <= 1'b0;
        pop({2'h1, 32'h0, 8'h3E});
        pop({2'h0, 32'h000003FE, 8'h00});
        apb(1'b1, `REG_CTRL_OFS, 32'h4);
        beat(1'b1, 1'b0, `KIND_MEM_WR, 11'h2, 8'h3C, 1'b0);
        beat(1'b0, 1'b0, `KIND_MEM_WR, 11'h2, 8'h3C, 1'b0);
        beat(1'b0, 1'b1, `KIND_MEM_WR, 11'h2, 8'h3C, 1'b0);
        src_valid <= 1'b0;
        pop({2'h1, 32'h0, 8'h3C});
        pop(42'h0);
        pop({2'h0, 32'h0000003C, 8'h00});
        repeat (3) @(posedge clk);
        chk("kept", 42'h8, kept);
        final_report;
    end
endmodule
